// File: pkg/cir_pkg.sv
// Constants for the cascaded interrupt router: register indices, field positions and reset values.
// Assumes a single clock domain and a word-addressed APB register map (byte address = index * 4).
`default_nettype none
package cir_pkg;
    localparam int NUM_LVL = 22;
    localparam int NUM_GP  = 11;
    localparam int NUM_EXT = 15;
    localparam int NUM_INT = 19;
    localparam int NUM_SRC = 34;

    localparam logic [4:0] MAP_NONE = 5'h00;
    localparam logic [4:0] MAP_NMI  = 5'h1F;
    localparam logic [4:0] MAP_MAXL = 5'h16;

    localparam logic [11:0] IDX_PIN_LO   = 12'hC20;
    localparam logic [11:0] IDX_PIN_HI   = 12'hC22;
    localparam logic [11:0] IDX_ICR      = 12'hD00;
    localparam logic [11:0] IDX_MODE_M   = 12'hD02;
    localparam logic [11:0] IDX_MODE_S1  = 12'hD03;
    localparam logic [11:0] IDX_MODE_S2  = 12'hD04;
    localparam logic [11:0] IDX_MASK_M   = 12'hD05;
    localparam logic [11:0] IDX_MASK_S1  = 12'hD06;
    localparam logic [11:0] IDX_MASK_S2  = 12'hD07;
    localparam logic [11:0] IDX_SW_LO    = 12'hD08;
    localparam logic [11:0] IDX_SW_HI    = 12'hD0A;
    localparam logic [11:0] IDX_POL      = 12'hD10;
    localparam logic [11:0] IDX_MAP_BASE = 12'hD20;
    localparam logic [11:0] IDX_VB_M     = 12'hE00;
    localparam logic [11:0] IDX_VB_S1    = 12'hE01;
    localparam logic [11:0] IDX_VB_S2    = 12'hE02;
    localparam logic [11:0] IDX_EOI_M    = 12'hE04;
    localparam logic [11:0] IDX_EOI_S1   = 12'hE05;
    localparam logic [11:0] IDX_EOI_S2   = 12'hE06;
    localparam logic [11:0] IDX_FERR     = 12'hE08;
    localparam logic [11:0] IDX_ISR      = 12'hE0C;
    localparam logic [11:0] IDX_IRR      = 12'hE0D;

    localparam int ICR_GLB_LVL = 0;
    localparam int ICR_PER_CH  = 1;
    localparam int ICR_NMI_EN  = 2;
    localparam int SW_NMI_BIT  = 7;
    localparam int FERR_CLR    = 0;

    localparam logic [7:0] RST_MASK  = 8'h00;
    localparam logic [7:0] RST_VB_M  = 8'h08;
    localparam logic [7:0] RST_VB_S1 = 8'h70;
    localparam logic [7:0] RST_VB_S2 = 8'h78;

    localparam logic [2:0] CASC_A   = 3'h2;
    localparam logic [2:0] CASC_B   = 3'h5;
    localparam logic [2:0] SPURIOUS = 3'h7;
endpackage
`default_nettype wire

// File: core/cir_chan8.sv
// One eight-channel prioritised controller with request, in-service and mask handling.
// Assumes acknowledge and end-of-interrupt arrive as one-cycle pulses from the top level.
`default_nettype none
module cir_chan8
    import cir_pkg::*;
(
    input  wire logic       mclk_in,
    input  wire logic       rstn_in,
    input  wire logic [7:0] req_in,
    input  wire logic [7:0] lvl_mode_in,
    input  wire logic [7:0] mask_in,
    input  wire logic       ack_in,
    input  wire logic       eoi_in,
    output logic            int_out,
    output logic [2:0]      chan_out,
    output logic [7:0]      isr_out,
    output logic [7:0]      irr_out
);
    logic [7:0] req_d_ff;
    logic [7:0] irr_ff;
    logic [7:0] isr_ff;

    function automatic logic [3:0] first_set(input logic [7:0] v);
        first_set = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) first_set = {1'b1, 3'(i)};
        end
    endfunction

    wire [7:0] rise    = req_in & ~req_d_ff;
    wire [7:0] pend    = irr_ff & ~mask_in;
    wire [3:0] win     = first_set(pend);
    wire [3:0] svc     = first_set(isr_ff);
    wire       take    = ack_in & int_out;
    wire [7:0] ack_vec = take ? (8'h01 << win[2:0]) : 8'h00;
    wire [7:0] eoi_vec = (eoi_in & svc[3]) ? (8'h01 << svc[2:0]) : 8'h00;
    wire [7:0] edge_nx = (irr_ff & ~ack_vec) | rise;

    // Lowest channel number wins; a pending request only interrupts a less urgent service.
    assign int_out  = win[3] & (~svc[3] | (win[2:0] < svc[2:0]));
    assign chan_out = win[2:0];
    assign isr_out  = isr_ff;
    assign irr_out  = irr_ff;

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            req_d_ff <= 8'h00;
            irr_ff   <= 8'h00;
            isr_ff   <= 8'h00;
        end else begin
            req_d_ff <= req_in;
            irr_ff   <= (lvl_mode_in & req_in) | (~lvl_mode_in & edge_nx);
            isr_ff   <= (isr_ff & ~eoi_vec) | ack_vec;
        end
    end

    a_edge_latch: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (rise[0] && !lvl_mode_in[0]) |=> irr_ff[0]) else $error("edge request not latched");
    a_ack_service: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        take |=> isr_ff[$past(win[2:0])]) else $error("acknowledged channel not in service");
    a_prio_order: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        int_out |-> pend[chan_out] && ((pend & ((8'h01 << chan_out) - 8'h01)) == 8'h00))
        else $error("pending channel of higher priority skipped");
endmodule
`default_nettype wire

// File: core/cir_router.sv
// Source conditioning and routing: polarity, pin-function gating and per-source mapping.
// Assumes mapping codes 1 to 22 select a level, the NMI code selects NMI, others route nowhere.
`default_nettype none
module cir_router
    import cir_pkg::*;
#(
    parameter int NSRC = NUM_SRC
) (
    input  wire logic [NUM_GP-1:0]  gp_irq_in,
    input  wire logic [3:0]         pci_irq_in,
    input  wire logic [NUM_EXT-1:0] pol_in,
    input  wire logic [NUM_GP-1:0]  pin_en_in,
    input  wire logic [NUM_INT-1:0] int_src_in,
    input  wire logic [NSRC*5-1:0]  map_in,
    output logic [NUM_LVL-1:0]      lvl_out,
    output logic                    nmi_out
);
    if (NSRC != NUM_EXT + NUM_INT) begin : g_bad_nsrc
        $error("NSRC must equal external plus internal sources");
    end

    wire [NUM_EXT-1:0] ext_raw = {pci_irq_in, gp_irq_in};
    wire [NUM_EXT-1:0] ext_gate = {4'hF, pin_en_in};
    wire [NUM_EXT-1:0] ext_act = (ext_raw ^ pol_in) & ext_gate;
    wire [NSRC-1:0]    src = {int_src_in, ext_act};

    always_comb begin
        logic [4:0] code;
        code    = MAP_NONE;
        lvl_out = '0;
        nmi_out = 1'b0;
        for (int s = 0; s < NSRC; s++) begin
            code = map_in[s*5 +: 5];
            if (code == MAP_NMI) begin
                nmi_out = nmi_out | src[s];
            end else if (code != MAP_NONE && code <= MAP_MAXL) begin
                lvl_out[5'(code - 5'h01)] = lvl_out[5'(code - 5'h01)] | src[s];
            end
        end
    end
endmodule
`default_nettype wire

// File: core/cir_top.sv
// Cascaded interrupt router top: APB registers, router, three eight-channel controllers and CPU side.
// Assumes inta_in is a one-cycle acknowledge from the core and APB is driven on mclk_in.
//
// Overview of operation
// - One master and two slave controllers; the master arbitrates and signals the core.
// - Master channel 2 takes slave 1 output, master channel 5 takes slave 2.
// - Three eight-channel controllers give 22 maskable channels of distinct priority.
// - Level 1 is served first, level 22 last.
// - Each source is routed to any one of the 22 channels by software.
// - A source may instead be routed to the non-maskable interrupt output.
// - A global setting makes all channels edge-triggered or all level-sensitive.
// - Optionally, each channel chooses edge or level detection by itself.
// - Fifteen external requests: eleven general pins and four PCI-style lines.
// - Nineteen internal requests (eighteen peripheral lines and the floating-point error) are detected and routed like external ones.
// - Software can raise any of the 22 levels and the NMI.
// - Each external input has a programmable inverter for active-high or active-low use.
// - Core floating-point error becomes a source, with clear and ignore-error output.
// - Selecting the interrupt function for a shared pin takes it from the I/O port.
// - The PCI-style inputs get the same detection, polarity and routing options.
// - Every source has its own mapping register selecting a channel or NMI.
// - Each controller has a mode register with one edge-or-level bit per channel.
`default_nettype none
module cir_top
    import cir_pkg::*;
(
    input  wire logic               mclk_in,
    input  wire logic               rstn_in,
    input  wire logic               psel_in,
    input  wire logic               penable_in,
    input  wire logic               pwrite_in,
    input  wire logic [15:0]        paddr_in,
    input  wire logic [31:0]        pwdata_in,
    output logic [31:0]             prdata_out,
    output logic                    pready_out,
    output logic                    pslverr_out,
    input  wire logic [NUM_GP-1:0]  gp_irq_in,
    input  wire logic [3:0]         pci_irq_in,
    input  wire logic [NUM_INT-2:0] periph_irq_in,
    input  wire logic               ferr_in,
    input  wire logic               inta_in,
    output logic                    intr_out,
    output logic                    nmi_out,
    output logic [7:0]              vector_out,
    output logic                    vector_valid_out,
    output logic                    ignne_out,
    output logic [NUM_GP-1:0]       gp_pin_taken_out
);
    logic [15:0]          pin_lo_ff;
    logic [15:0]          pin_hi_ff;
    logic [2:0]           icr_ff;
    logic [7:0]           mode_ff [3];
    logic [7:0]           mask_ff [3];
    logic [7:0]           vb_ff   [3];
    logic [NUM_LVL-1:0]   sw_lvl_ff;
    logic                 sw_nmi_ff;
    logic [NUM_EXT-1:0]   pol_ff;
    logic [4:0]           map_ff  [NUM_SRC];
    logic                 ferr_d_ff;
    logic                 ferr_lat_ff;
    logic                 ignne_ff;
    logic                 intr_ff;
    logic                 nmi_ff;
    logic [7:0]           vec_ff;
    logic                 vec_vld_ff;
    logic [31:0]          rdata_ff;
    logic                 ready_ff;
    logic                 err_ff;
    logic [NUM_GP-1:0]    taken_ff;

    // APB decode: one aligned word per register, index taken from paddr[13:2].
    wire [11:0] idx      = paddr_in[13:2];
    wire        addr_ok  = (paddr_in[1:0] == 2'h0) && (paddr_in[15:14] == 2'h0);
    wire        setup    = psel_in & ~penable_in & ~ready_ff;
    wire        wr_fire  = psel_in & penable_in & ready_ff & pwrite_in;
    wire        in_map   = (idx >= IDX_MAP_BASE) && (idx < IDX_MAP_BASE + 12'(NUM_SRC));
    wire [5:0]  map_sel  = 6'(idx - IDX_MAP_BASE);
    wire        wr_eoi_m  = wr_fire && idx == IDX_EOI_M;
    wire        wr_eoi_s1 = wr_fire && idx == IDX_EOI_S1;
    wire        wr_eoi_s2 = wr_fire && idx == IDX_EOI_S2;
    wire        ferr_clr  = wr_fire && idx == IDX_FERR && pwdata_in[FERR_CLR];

    // Pin-function bits for the general request pins, listed from pin 10 down to pin 0.
    wire [NUM_GP-1:0] pin_en = {pin_lo_ff[13], pin_lo_ff[14], pin_lo_ff[15],
                                pin_hi_ff[0], pin_hi_ff[1], pin_hi_ff[2], pin_hi_ff[3],
                                pin_hi_ff[4], pin_hi_ff[5], pin_hi_ff[6], pin_hi_ff[7]};

    // Floating-point error is latched on its rising edge and stays until software clears it.
    wire ferr_rise = ferr_in & ~ferr_d_ff;
    wire [NUM_INT-1:0] int_src = {ferr_lat_ff, periph_irq_in};

    logic [NUM_SRC*5-1:0] map_flat;
    always_comb begin
        map_flat = '0;
        for (int s = 0; s < NUM_SRC; s++) begin
            map_flat[s*5 +: 5] = map_ff[s];
        end
    end

    logic [NUM_LVL-1:0] hw_lvl;
    logic               hw_nmi;

    cir_router #(
        .NSRC       (NUM_SRC)
    ) u_router (
        .gp_irq_in  (gp_irq_in),
        .pci_irq_in (pci_irq_in),
        .pol_in     (pol_ff),
        .pin_en_in  (pin_en),
        .int_src_in (int_src),
        .map_in     (map_flat),
        .lvl_out    (hw_lvl),
        .nmi_out    (hw_nmi)
    );

    wire [NUM_LVL-1:0] lvl = hw_lvl | sw_lvl_ff;

    // Level-to-channel layout: levels 3-10 on slave 1, 13-20 on slave 2, the rest on the master.
    logic [7:0] m_req;
    logic [7:0] s1_req;
    logic [7:0] s2_req;
    logic       s1_int;
    logic       s2_int;
    assign s1_req = lvl[9:2];
    assign s2_req = lvl[19:12];
    assign m_req  = {lvl[21], lvl[20], s2_int, lvl[11], lvl[10], s1_int, lvl[1], lvl[0]};

    // Mode selection: per-channel bits when enabled, otherwise the global bit for all.
    logic [7:0] eff_mode [3];
    for (genvar c = 0; c < 3; c++) begin : g_mode
        assign eff_mode[c] = icr_ff[ICR_PER_CH] ? mode_ff[c] : {8{icr_ff[ICR_GLB_LVL]}};
    end
    // Cascade channels follow the slave output as a level.
    wire [7:0] casc_lvl = (8'h01 << CASC_A) | (8'h01 << CASC_B);
    wire [7:0] m_mode   = eff_mode[0] | casc_lvl;

    logic       m_int;
    logic [2:0] m_ch;
    logic [2:0] s1_ch;
    logic [2:0] s2_ch;
    logic [7:0] isr_m;
    logic [7:0] isr_s1;
    logic [7:0] isr_s2;
    logic [7:0] irr_m;
    logic [7:0] irr_s1;
    logic [7:0] irr_s2;

    wire ack_m  = inta_in & m_int;
    wire ack_s1 = ack_m & (m_ch == CASC_A);
    wire ack_s2 = ack_m & (m_ch == CASC_B);

    cir_chan8 u_master (
        .mclk_in     (mclk_in),
        .rstn_in     (rstn_in),
        .req_in      (m_req),
        .lvl_mode_in (m_mode),
        .mask_in     (mask_ff[0]),
        .ack_in      (ack_m),
        .eoi_in      (wr_eoi_m),
        .int_out     (m_int),
        .chan_out    (m_ch),
        .isr_out     (isr_m),
        .irr_out     (irr_m)
    );

    cir_chan8 u_slave1 (
        .mclk_in     (mclk_in),
        .rstn_in     (rstn_in),
        .req_in      (s1_req),
        .lvl_mode_in (eff_mode[1]),
        .mask_in     (mask_ff[1]),
        .ack_in      (ack_s1),
        .eoi_in      (wr_eoi_s1),
        .int_out     (s1_int),
        .chan_out    (s1_ch),
        .isr_out     (isr_s1),
        .irr_out     (irr_s1)
    );

    cir_chan8 u_slave2 (
        .mclk_in     (mclk_in),
        .rstn_in     (rstn_in),
        .req_in      (s2_req),
        .lvl_mode_in (eff_mode[2]),
        .mask_in     (mask_ff[2]),
        .ack_in      (ack_s2),
        .eoi_in      (wr_eoi_s2),
        .int_out     (s2_int),
        .chan_out    (s2_ch),
        .isr_out     (isr_s2),
        .irr_out     (irr_s2)
    );

    // Vector: base high bits plus the winning channel; no winner gives the spurious channel.
    wire [7:0] nxt_vec = !m_int           ? {vb_ff[0][7:3], SPURIOUS} :
                         ack_s1           ? {vb_ff[1][7:3], s1_ch} :
                         ack_s2           ? {vb_ff[2][7:3], s2_ch} :
                                            {vb_ff[0][7:3], m_ch};
    wire       nxt_nmi = icr_ff[ICR_NMI_EN] & (hw_nmi | sw_nmi_ff);

    logic [31:0] nxt_rdata;
    always_comb begin
        nxt_rdata = 32'h0;
        if (in_map) begin
            nxt_rdata = {27'h0, map_ff[map_sel]};
        end else begin
            unique case (idx)
                IDX_PIN_LO:  nxt_rdata = {16'h0, pin_lo_ff};
                IDX_PIN_HI:  nxt_rdata = {16'h0, pin_hi_ff};
                IDX_ICR:     nxt_rdata = {29'h0, icr_ff};
                IDX_MODE_M:  nxt_rdata = {24'h0, mode_ff[0]};
                IDX_MODE_S1: nxt_rdata = {24'h0, mode_ff[1]};
                IDX_MODE_S2: nxt_rdata = {24'h0, mode_ff[2]};
                IDX_MASK_M:  nxt_rdata = {24'h0, mask_ff[0]};
                IDX_MASK_S1: nxt_rdata = {24'h0, mask_ff[1]};
                IDX_MASK_S2: nxt_rdata = {24'h0, mask_ff[2]};
                IDX_SW_LO:   nxt_rdata = {16'h0, sw_lvl_ff[15:0]};
                IDX_SW_HI:   nxt_rdata = {24'h0, sw_nmi_ff, 1'b0, sw_lvl_ff[21:16]};
                IDX_POL:     nxt_rdata = {17'h0, pol_ff};
                IDX_VB_M:    nxt_rdata = {24'h0, vb_ff[0]};
                IDX_VB_S1:   nxt_rdata = {24'h0, vb_ff[1]};
                IDX_VB_S2:   nxt_rdata = {24'h0, vb_ff[2]};
                IDX_FERR:    nxt_rdata = {30'h0, ignne_ff, ferr_lat_ff};
                IDX_ISR:     nxt_rdata = {8'h0, isr_s2, isr_s1, isr_m};
                IDX_IRR:     nxt_rdata = {8'h0, irr_s2, irr_s1, irr_m};
                default:     nxt_rdata = 32'h0;
            endcase
        end
    end

    wire known = in_map || idx inside {IDX_PIN_LO, IDX_PIN_HI, IDX_ICR, IDX_MODE_M, IDX_MODE_S1,
        IDX_MODE_S2, IDX_MASK_M, IDX_MASK_S1, IDX_MASK_S2, IDX_SW_LO, IDX_SW_HI, IDX_POL,
        IDX_VB_M, IDX_VB_S1, IDX_VB_S2, IDX_EOI_M, IDX_EOI_S1, IDX_EOI_S2, IDX_FERR,
        IDX_ISR, IDX_IRR};

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            ready_ff <= 1'b0;
            err_ff   <= 1'b0;
            rdata_ff <= 32'h0;
        end else begin
            ready_ff <= setup;
            err_ff   <= setup & ~(addr_ok & known);
            rdata_ff <= (setup & addr_ok & ~pwrite_in) ? nxt_rdata : 32'h0;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            pin_lo_ff <= 16'h0;
            pin_hi_ff <= 16'h0;
            icr_ff    <= 3'h0;
            sw_lvl_ff <= '0;
            sw_nmi_ff <= 1'b0;
            pol_ff    <= '0;
            mode_ff   <= '{default: 8'h00};
            mask_ff   <= '{default: RST_MASK};
            vb_ff     <= '{RST_VB_M, RST_VB_S1, RST_VB_S2};
            map_ff    <= '{default: MAP_NONE};
        end else if (wr_fire && addr_ok) begin
            if (in_map) map_ff[map_sel] <= pwdata_in[4:0];
            if (idx == IDX_PIN_LO)  pin_lo_ff <= pwdata_in[15:0];
            if (idx == IDX_PIN_HI)  pin_hi_ff <= pwdata_in[15:0];
            if (idx == IDX_ICR)     icr_ff    <= pwdata_in[2:0];
            if (idx == IDX_MODE_M)  mode_ff[0] <= pwdata_in[7:0];
            if (idx == IDX_MODE_S1) mode_ff[1] <= pwdata_in[7:0];
            if (idx == IDX_MODE_S2) mode_ff[2] <= pwdata_in[7:0];
            if (idx == IDX_MASK_M)  mask_ff[0] <= pwdata_in[7:0];
            if (idx == IDX_MASK_S1) mask_ff[1] <= pwdata_in[7:0];
            if (idx == IDX_MASK_S2) mask_ff[2] <= pwdata_in[7:0];
            if (idx == IDX_SW_LO)   sw_lvl_ff[15:0] <= pwdata_in[15:0];
            if (idx == IDX_SW_HI) begin
                sw_lvl_ff[21:16] <= pwdata_in[5:0];
                sw_nmi_ff        <= pwdata_in[SW_NMI_BIT];
            end
            if (idx == IDX_POL)     pol_ff <= pwdata_in[NUM_EXT-1:0];
            if (idx == IDX_VB_M)    vb_ff[0] <= pwdata_in[7:0];
            if (idx == IDX_VB_S1)   vb_ff[1] <= pwdata_in[7:0];
            if (idx == IDX_VB_S2)   vb_ff[2] <= pwdata_in[7:0];
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            ferr_d_ff   <= 1'b0;
            ferr_lat_ff <= 1'b0;
            ignne_ff    <= 1'b0;
        end else begin
            ferr_d_ff   <= ferr_in;
            ferr_lat_ff <= ferr_rise | (ferr_lat_ff & ~ferr_clr);
            ignne_ff    <= ferr_in & (ignne_ff | ferr_clr);
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            intr_ff    <= 1'b0;
            nmi_ff     <= 1'b0;
            vec_ff     <= 8'h00;
            vec_vld_ff <= 1'b0;
            taken_ff   <= '0;
        end else begin
            intr_ff    <= m_int & ~inta_in;
            nmi_ff     <= nxt_nmi;
            vec_vld_ff <= inta_in;
            vec_ff     <= inta_in ? nxt_vec : vec_ff;
            taken_ff   <= pin_en;
        end
    end

    assign prdata_out       = rdata_ff;
    assign pready_out       = ready_ff;
    assign pslverr_out      = err_ff;
    assign intr_out         = intr_ff;
    assign nmi_out          = nmi_ff;
    assign vector_out       = vec_ff;
    assign vector_valid_out = vec_vld_ff;
    assign ignne_out        = ignne_ff;
    assign gp_pin_taken_out = taken_ff;

    a_casc_slave1: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (inta_in && m_int && m_ch == CASC_A) |=> vector_out[7:3] == vb_ff[1][7:3])
        else $error("slave 1 vector not delivered");
    a_sw_nmi: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (sw_nmi_ff && icr_ff[ICR_NMI_EN]) |=> nmi_out) else $error("software NMI lost");
    a_ferr_ignne: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (ferr_clr && ferr_in) |=> ignne_out && (ferr_lat_ff == $past(ferr_rise))) else $error("ferr clear failed");
    a_apb_answer: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (psel_in && !penable_in && !pready_out) |=> pready_out) else $error("apb answer late");
    a_pin_gate: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        $rose(pin_lo_ff[13]) |=> gp_pin_taken_out[10]) else $error("pin 10 not taken");
endmodule
`default_nettype wire

// File: tb/cir_cpu_model.sv
// Processor core model: acknowledges a pending maskable request after a chosen delay.
// Assumes the router answers each acknowledge pulse with one vector-valid pulse.
`default_nettype none
module cir_cpu_model (
    input  wire logic       mclk_in,
    input  wire logic       rstn_in,
    input  wire logic       intr_in,
    input  wire logic       vector_valid_in,
    input  wire logic [7:0] dly_in,
    output logic            inta_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_ff;
    logic       busy_ff;
    // One acknowledge per request, and none again until the vector has been delivered.
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            cnt_ff   <= 8'h00;
            busy_ff  <= 1'b0;
            inta_out <= 1'b0;
        end else begin
            inta_out <= 1'b0;
            if (busy_ff) begin
                busy_ff <= !vector_valid_in;
            end else if (intr_in && cnt_ff >= dly_in) begin
                inta_out <= 1'b1;
                busy_ff  <= 1'b1;
                cnt_ff   <= 8'h00;
            end else begin
                cnt_ff <= intr_in ? cnt_ff + 8'h01 : 8'h00;
            end
        end
    end
endmodule
`default_nettype wire

// File: tb/cir_top_tb.sv
// Self-checking bench: APB master, core model and a queue of expected vectors.
// Assumes the package constants and the core model in cir_cpu_model.
`default_nettype none
module cir_top_tb
    import cir_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk_in = 1'b0, rstn_in = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, ferr = 1'b0;
    logic        pready, pslverr, intr, nmi, vvalid, ignne, inta, err;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [10:0] gp_irq = 11'h000, taken;
    logic [3:0]  pci_irq = 4'h0;
    logic [17:0] periph = 18'h00000;
    logic [7:0]  vector, dly = 8'h00;
    logic [11:0] ridx[5] = '{IDX_VB_M, IDX_VB_S1, IDX_VB_S2, IDX_MASK_M, 12'hFFF};
    logic [7:0]  rexp[5] = '{RST_VB_M, RST_VB_S1, RST_VB_S2, RST_MASK, 8'h00};
    int          bad_count = 0, check_count = 0, got = 0, cyc = 0, seed = 32'hfde5d291;
    int          exp_q[$];
    always #5 mclk_in = ~mclk_in;
    cir_top dut (.mclk_in(mclk_in), .rstn_in(rstn_in), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
        .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .gp_irq_in(gp_irq), .pci_irq_in(pci_irq), .periph_irq_in(periph), .ferr_in(ferr), .inta_in(inta),
        .intr_out(intr), .nmi_out(nmi), .vector_out(vector), .vector_valid_out(vvalid), .ignne_out(ignne),
        .gp_pin_taken_out(taken));
    cir_cpu_model cpu (.mclk_in(mclk_in), .rstn_in(rstn_in), .intr_in(intr), .vector_valid_in(vvalid),
        .dly_in(dly), .inta_out(inta));
    task automatic give_verdict();
        $display("checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] wd);
        @(posedge mclk_in);
        psel <= 1'b1;
        pwr <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge mclk_in);
        pen <= 1'b1;
        do @(posedge mclk_in); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    // Vector of each level from its controller, channel and base.
    function automatic int l2v(input int l);
        if (l <= 2) return RST_VB_M + l - 1;
        if (l <= 10) return RST_VB_S1 + l - 3;
        if (l <= 12) return RST_VB_M + l - 8;
        if (l <= 20) return RST_VB_S2 + l - 13;
        return RST_VB_M + l - 15;
    endfunction
    task automatic eoi(input int l);
        if (l > 2 && l < 11) apb(1'b1, IDX_EOI_S1, 32'h0);
        if (l > 12 && l < 21) apb(1'b1, IDX_EOI_S2, 32'h0);
        apb(1'b1, IDX_EOI_M, 32'h0);
    endtask
    task automatic wait_vec(input int n);
        while (got < n) @(posedge mclk_in);
    endtask
    task automatic sw(input logic [21:0] m);
        apb(1'b1, IDX_SW_LO, {16'h0000, m[15:0]});
        apb(1'b1, IDX_SW_HI, {26'h0, m[21:16]});
    endtask
    task automatic pair(input int a, input int b);
        int lo, hi, n;
        lo = a < b ? a : b;
        hi = a < b ? b : a;
        n = got;
        exp_q.push_back(l2v(lo));
        if (hi != lo) exp_q.push_back(l2v(hi));
        sw((22'h1 << (a - 1)) | (22'h1 << (b - 1)));
        wait_vec(n + 1);
        eoi(lo);
        if (hi != lo) wait_vec(n + 2);
        if (hi != lo) eoi(hi);
        sw(22'h0);
    endtask
    always @(posedge mclk_in) begin
        cyc++;
        periph <= {periph[16:0], ~periph[17]};
        pci_irq <= periph[3:0];
        if (vvalid === 1'b1) begin
            chk("vector", exp_q.size() > 0 ? exp_q.pop_front() : -1, vector);
            got++;
        end
        if (cyc == 20000) begin
            bad_count++;
            give_verdict();
        end
    end
    initial begin
        int a, b, n;
        repeat (5) @(posedge mclk_in);
        rstn_in <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, ridx[i], 32'h0);
            chk("reset_read", rexp[i], rd);
            chk("slverr", i == 4, err);
        end
        apb(1'b1, IDX_PIN_HI, 32'h80);
        apb(1'b1, IDX_PIN_LO, 32'h2000);
        repeat (3) @(posedge mclk_in);
        chk("pin_taken", 11'h401, taken);
        for (int l = 1; l <= 22; l++) pair(l, l);
        dly <= 8'd20;
        repeat (4) begin
            a = 1 + (($random(seed) & 32'h7FFFFFFF) % 22);
            b = 1 + (($random(seed) & 32'h7FFFFFFF) % 22);
            pair(a, b);
        end
        dly <= 8'd0;
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, IDX_ICR, i ? 32'h2 : 32'h1);
            apb(1'b1, IDX_MODE_M, i ? 32'h2 : 32'h0);
            n = got;
            exp_q.push_back(9);
            exp_q.push_back(9);
            apb(1'b1, IDX_POL, 32'h1);
            apb(1'b1, IDX_MAP_BASE, 32'h2);
            wait_vec(n + 1);
            eoi(2);
            wait_vec(n + 2);
            gp_irq[0] <= 1'b1;
            eoi(2);
            repeat (10) @(posedge mclk_in);
            chk("level_count", n + 2, got);
            apb(1'b1, IDX_MAP_BASE, 32'h0);
            apb(1'b1, IDX_POL, 32'h0);
            gp_irq[0] <= 1'b0;
        end
        apb(1'b1, IDX_MAP_BASE, 32'h1F);
        gp_irq[0] <= 1'b1;
        repeat (3) @(posedge mclk_in);
        chk("nmi_off", 0, nmi);
        chk("intr_idle", 0, intr);
        apb(1'b1, IDX_ICR, 32'h4);
        repeat (3) @(posedge mclk_in);
        chk("nmi_hw", 1, nmi);
        gp_irq[0] <= 1'b0;
        repeat (3) @(posedge mclk_in);
        chk("nmi_idle", 0, nmi);
        apb(1'b1, IDX_SW_HI, 32'h80);
        repeat (3) @(posedge mclk_in);
        chk("nmi", 1, nmi);
        n = got;
        exp_q.push_back(l2v(1));
        apb(1'b1, IDX_MAP_BASE + 12'd33, 32'h1);
        ferr <= 1'b1;
        wait_vec(n + 1);
        apb(1'b0, IDX_FERR, 32'h0);
        chk("ferr_latch", 1, rd[0]);
        apb(1'b1, IDX_FERR, 32'h1);
        repeat (2) @(posedge mclk_in);
        chk("ignne", 1, ignne);
        apb(1'b0, IDX_FERR, 32'h0);
        chk("ferr_clear", 2, rd[1:0]);
        give_verdict();
    end
endmodule
`default_nettype wire
